/* eag_cfg.svh */
// eag_cfg.svh: offsets, field positions, reset values and literal widths
// assumes: included by bare name wherever these constants are needed
`ifndef EAG_CFG_SVH
`define EAG_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb port
// ----------------------------------------------------------------------
`define EAG_OFS_MODCTL   8'h00
`define EAG_OFS_XSTART   8'h04
`define EAG_OFS_XEND     8'h08
`define EAG_OFS_YSTART   8'h0C
`define EAG_OFS_YEND     8'h10
`define EAG_OFS_BREV     8'h14
`define EAG_OFS_LASTEA   8'h18
`define EAG_PTR_BASE     2'b01
`define EAG_PTR_IDX_MSB  5
`define EAG_PTR_IDX_LSB  2
`define EAG_PTR_SEL_MSB  7
`define EAG_PTR_SEL_LSB  6

// ----------------------------------------------------------------------
// modulo_control fields
// ----------------------------------------------------------------------
`define EAG_XSEL_MSB     3
`define EAG_XSEL_LSB     0
`define EAG_YSEL_MSB     7
`define EAG_YSEL_LSB     4
`define EAG_BSEL_MSB     11
`define EAG_BSEL_LSB     8
`define EAG_XEN_BIT      15
`define EAG_YEN_BIT      14
`define EAG_SEL_NONE     4'hF

// ----------------------------------------------------------------------
// bit-reverse control fields
// ----------------------------------------------------------------------
`define EAG_BREN_BIT     15
`define EAG_XB_MSB       14

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EAG_MODCTL_RST   16'h0FFF
`define EAG_ZERO16       16'h0000

// ----------------------------------------------------------------------
// literal field widths and mac pointer range
// ----------------------------------------------------------------------
`define EAG_NEAR_BITS    13
`define EAG_LIT5_BITS    5
`define EAG_LIT10_BITS   10
`define EAG_LIT14_BITS   14
`define EAG_MAC_X0       4'd8
`define EAG_MAC_X1       4'd9
`define EAG_MAC_Y0       4'd10
`define EAG_MAC_Y1       4'd11

`endif

/* eag_pkg.sv */
// eag_pkg.sv: types shared by the address generator and its users
// assumes: nothing beyond a systemverilog compiler
package eag_pkg;

  // addressing mode supplied by the instruction decoder
  typedef enum logic [3:0] {
    MODE_FILE     = 4'h0,
    MODE_DIRECT   = 4'h1,
    MODE_LIT      = 4'h2,
    MODE_IND      = 4'h3,
    MODE_POST     = 4'h4,
    MODE_PRE      = 4'h5,
    MODE_ROFS     = 4'h6,
    MODE_LOFS     = 4'h7,
    MODE_MAC_IND  = 4'h8,
    MODE_MAC_POST = 4'h9,
    MODE_MAC_IDX  = 4'hA
  } mode_type;

  // which generator serves the access
  typedef enum logic [1:0] {
    GEN_XRD = 2'h0,
    GEN_XWR = 2'h1,
    GEN_Y   = 2'h2
  } gen_type;

  // literal field width
  typedef enum logic [1:0] {
    LIT_U5  = 2'h0,
    LIT_U10 = 2'h1,
    LIT_U14 = 2'h2,
    LIT_S16 = 2'h3
  } lit_type;

endpackage

/* effective_address_generator.sv */
// effective_address_generator.sv: effective-address datapath with pointer file,
// modulo correction, bit-reversed writes and an apb register slave
// assumes: decoder requests arrive on pclk; apb master on pclk
//
// What this block does
// RL1: file direct takes 13-bit near address
// RL2: first operand from base register, second register/literal
// RL3: accept 5-bit and 10-bit literal fields
// RL4: plain indirect: address is pointer, unchanged
// RL5: post-modify: old pointer addresses, then stepped
// RL6: pre-modify: pointer stepped first, new addresses
// RL7: register offset: pointer plus base register
// RL8: literal offset: pointer plus instruction literal
// RL9: move sides share one 4-bit offset field
// RL10: mac pointers 8..11; 8,9 X, 10,11 Y
// RL11: mac indexed only on registers 9 and 11
// RL12: mac indirect, indexed, post-step 2/4/6 only
// RL13: branch 16-bit signed, disable 14-bit unsigned literal
// RL14: one circular buffer each in X, Y
// RL15: power-of-two buffers check both boundaries
// RL16: buffers set by 16-bit start/end registers
// RL17: Y modulo addresses keep bit 0 clear
// RL18: select value 15 turns modulo off
// RL19: X modulo needs select not 15, bit 15
// RL20: Y modulo needs select not 15, bit 14
// RL21: boundary test is beyond limit, not equal
// RL22: write back corrected pointer only when modifying
// RL23: bit-reverse only X writes, modifier reversed
// RL24: wrap by overshoot from opposite boundary
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "eag_cfg.svh"

module effective_address_generator #(
  parameter int W = 16
) (
  // apb slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // decoder request
  input  wire logic               req_valid,
  input  wire eag_pkg::gen_type   req_gen,
  input  wire eag_pkg::mode_type  req_mode,
  input  wire logic [3:0]         req_ptr,
  input  wire logic [3:0]         req_base,
  input  wire logic [W-1:0]       req_lit,
  input  wire eag_pkg::lit_type   req_lit_width,
  input  wire logic [W-1:0]       req_step,
  input  wire logic [1:0]         req_mac_step,
  // result towards the data memory ports
  output logic                    ea_valid_q,
  output logic [W-1:0]            ea_addr_q,
  output logic                    ea_ydata_q,
  output logic                    ea_fault_q,
  output logic [W-1:0]            opnd1_q,
  output logic [W-1:0]            opnd2_q
);
  import eag_pkg::*;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // extend a literal field to the data width
  function automatic logic [W-1:0] lit_ext(input logic [W-1:0] l, input lit_type k);
    logic [W-1:0] r;
    r = '0;
    unique case (k)
      LIT_U5:  r[`EAG_LIT5_BITS-1:0] = l[`EAG_LIT5_BITS-1:0];   // see RL3 RL2
      LIT_U10: r[`EAG_LIT10_BITS-1:0] = l[`EAG_LIT10_BITS-1:0]; // see RL3
      LIT_U14: r[`EAG_LIT14_BITS-1:0] = l[`EAG_LIT14_BITS-1:0]; // see RL13
      LIT_S16: r = l;                                           // see RL13
    endcase
    return r;
  endfunction

  // circular correction: wrap by the overshoot from the far boundary
  function automatic logic [W-1:0] mod_fix(input logic [W-1:0] a, input logic [W-1:0] s,
                                           input logic [W-1:0] e, input logic up);
    logic [W-1:0] len;
    logic         both;
    logic [W-1:0] r;
    len  = e - s + {{(W-1){1'b0}}, 1'b1};                       // see RL16
    both = ((len & (len - {{(W-1){1'b0}}, 1'b1})) == '0);       // see RL15
    r    = a;
    if ((a > e) && (up || both))                                // see RL21
      r = a - len;                                              // see RL24
    else if ((a < s) && (!up || both))
      r = a + len;                                              // see RL24
    return r;
  endfunction

  // reverse the bit order of a word
  function automatic logic [W-1:0] rev(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W; i++) begin
      r[i] = v[W-1-i];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [W-1:0] modctl_q;
  logic [W-1:0] xstart_q;
  logic [W-1:0] xend_q;
  logic [W-1:0] ystart_q;
  logic [W-1:0] yend_q;
  logic [W-1:0] brev_q;
  logic [W-1:0] pfile_q [16];

  // apb decode: setup phase computes the answer, access phase completes it
  logic         setup;
  logic         apb_wr;
  logic         ptr_hit;
  logic         mapped;
  logic [3:0]   ptr_idx;
  logic [W-1:0] rd_v;

  assign setup   = psel && !penable;
  assign apb_wr  = psel && penable && pready && pwrite && !pslverr;
  assign ptr_hit = (paddr[`EAG_PTR_SEL_MSB:`EAG_PTR_SEL_LSB] == `EAG_PTR_BASE)
                   && (paddr[1:0] == 2'b00);
  assign ptr_idx = paddr[`EAG_PTR_IDX_MSB:`EAG_PTR_IDX_LSB];

  // read mux and address map
  always_comb begin
    mapped = 1'b1;
    rd_v   = '0;
    if (ptr_hit) begin
      rd_v = pfile_q[ptr_idx];
    end else begin
      unique case (paddr)
        `EAG_OFS_MODCTL: rd_v = modctl_q;
        `EAG_OFS_XSTART: rd_v = xstart_q;
        `EAG_OFS_XEND:   rd_v = xend_q;
        `EAG_OFS_YSTART: rd_v = ystart_q;
        `EAG_OFS_YEND:   rd_v = yend_q;
        `EAG_OFS_BREV:   rd_v = brev_q;
        `EAG_OFS_LASTEA: rd_v = ea_addr_q;
        default:         mapped = 1'b0;
      endcase
    end
  end

  // apb answer: ready one cycle after setup, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup ? {16'h0000, rd_v} : 32'h0000_0000;
    end
  end

  // control registers, written at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modctl_q <= `EAG_MODCTL_RST;
      xstart_q <= `EAG_ZERO16;
      xend_q   <= `EAG_ZERO16;
      ystart_q <= `EAG_ZERO16;
      yend_q   <= `EAG_ZERO16;
      brev_q   <= `EAG_ZERO16;
    end else if (apb_wr && !ptr_hit) begin
      unique case (paddr)
        `EAG_OFS_MODCTL: modctl_q <= pwdata[W-1:0];
        `EAG_OFS_XSTART: xstart_q <= pwdata[W-1:0];   // see RL16
        `EAG_OFS_XEND:   xend_q   <= pwdata[W-1:0];   // see RL16
        `EAG_OFS_YSTART: ystart_q <= pwdata[W-1:0];
        `EAG_OFS_YEND:   yend_q   <= pwdata[W-1:0];
        `EAG_OFS_BREV:   brev_q   <= pwdata[W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // address datapath
  // ----------------------------------------------------------------------
  logic [W-1:0] ptr_v;
  logic [W-1:0] base_v;
  logic [W-1:0] lit_v;
  logic [W-1:0] step_v;
  logic [W-1:0] ea_d;
  logic [W-1:0] newptr_d;
  logic         wrbk_d;
  logic         uses_ptr;
  logic         fault_d;
  logic         ydata_d;
  logic         mod_x_act;
  logic         mod_y_act;
  logic         brev_act;
  logic         is_mac;
  gen_type      gen_v;

  assign ptr_v  = pfile_q[req_ptr];
  assign base_v = pfile_q[req_base];      // one shared offset field, see RL9 RL2
  assign lit_v  = lit_ext(req_lit, req_lit_width);
  assign is_mac = (req_mode == MODE_MAC_IND) || (req_mode == MODE_MAC_POST)
                  || (req_mode == MODE_MAC_IDX);
  // modulo only where a pointer forms the address, never for direct or literal forms
  assign uses_ptr = (req_mode != MODE_FILE) && (req_mode != MODE_DIRECT)
                    && (req_mode != MODE_LIT);

  // mac pointers route by register number
  always_comb begin
    gen_v   = req_gen;
    fault_d = 1'b0;
    if (is_mac) begin
      if (req_ptr == `EAG_MAC_X0 || req_ptr == `EAG_MAC_X1)
        gen_v = GEN_XRD;                                        // see RL10
      else if (req_ptr == `EAG_MAC_Y0 || req_ptr == `EAG_MAC_Y1)
        gen_v = GEN_Y;                                          // see RL10
      else
        fault_d = 1'b1;                                         // see RL10
      if (req_mode == MODE_MAC_IDX && req_ptr != `EAG_MAC_X1 && req_ptr != `EAG_MAC_Y1)
        fault_d = 1'b1;                                         // see RL11
      if (req_mode == MODE_MAC_POST && req_mac_step == 2'd0)
        fault_d = 1'b1;                                         // see RL12
    end
  end

  // one X and one Y buffer, each keyed to one selected pointer
  assign mod_x_act = uses_ptr && (gen_v != GEN_Y) && modctl_q[`EAG_XEN_BIT]
                     && (modctl_q[`EAG_XSEL_MSB:`EAG_XSEL_LSB] != `EAG_SEL_NONE)
                     && (req_ptr == modctl_q[`EAG_XSEL_MSB:`EAG_XSEL_LSB]);  // see RL19 RL18 RL14
  assign mod_y_act = uses_ptr && (gen_v == GEN_Y) && modctl_q[`EAG_YEN_BIT]
                     && (modctl_q[`EAG_YSEL_MSB:`EAG_YSEL_LSB] != `EAG_SEL_NONE)
                     && (req_ptr == modctl_q[`EAG_YSEL_MSB:`EAG_YSEL_LSB]);  // see RL20 RL18 RL14
  // bit-reverse wins over modulo, on X writes with modifying modes only
  assign brev_act  = (gen_v == GEN_XWR) && brev_q[`EAG_BREN_BIT]
                     && (modctl_q[`EAG_BSEL_MSB:`EAG_BSEL_LSB] != `EAG_SEL_NONE)
                     && (req_ptr == modctl_q[`EAG_BSEL_MSB:`EAG_BSEL_LSB])
                     && (req_mode == MODE_PRE || req_mode == MODE_POST);     // see RL23

  // modifier: decoder step, or 2/4/6 for mac post-step
  assign step_v = (req_mode == MODE_MAC_POST)
                  ? {{(W-3){1'b0}}, req_mac_step, 1'b0} : req_step;         // see RL12

  // effective address, new pointer and write-back decision
  always_comb begin
    logic [W-1:0] add_v;
    logic [W-1:0] raw_v;
    logic [W-1:0] cor_v;
    add_v    = '0;
    raw_v    = ptr_v;
    cor_v    = ptr_v;
    ea_d     = ptr_v;
    newptr_d = ptr_v;
    wrbk_d   = 1'b0;
    ydata_d  = (gen_v == GEN_Y);
    unique case (req_mode)
      MODE_FILE:                 ea_d = {{(W-`EAG_NEAR_BITS){1'b0}},
                                         req_lit[`EAG_NEAR_BITS-1:0]};      // see RL1
      MODE_DIRECT, MODE_LIT:     ea_d = '0;
      MODE_IND, MODE_MAC_IND:    add_v = '0;                                // see RL4 RL12
      MODE_POST, MODE_MAC_POST:  add_v = step_v;                            // see RL5
      MODE_PRE:                  add_v = step_v;                            // see RL6
      MODE_ROFS, MODE_MAC_IDX:   add_v = base_v;                            // see RL7 RL11
      MODE_LOFS:                 add_v = lit_v;                             // see RL8
      default:                   add_v = '0;
    endcase
    raw_v = ptr_v + add_v;
    cor_v = raw_v;
    if (mod_x_act)
      cor_v = mod_fix(raw_v, xstart_q, xend_q, !add_v[W-1]);
    else if (mod_y_act)
      cor_v = mod_fix(raw_v, ystart_q, yend_q, !add_v[W-1]) & ~{{(W-1){1'b0}}, 1'b1}; // see RL17
    if (brev_act)
      cor_v = rev(rev(ptr_v) + rev({brev_q[`EAG_XB_MSB:0], 1'b0}))
              & ~{{(W-1){1'b0}}, 1'b1};                                     // see RL23
    unique case (req_mode)
      MODE_POST, MODE_MAC_POST: begin
        ea_d     = ptr_v;                                                   // see RL5
        newptr_d = cor_v;
        wrbk_d   = !fault_d;                                                // see RL22
      end
      MODE_PRE: begin
        ea_d     = cor_v;                                                   // see RL6
        newptr_d = cor_v;
        wrbk_d   = 1'b1;                                                    // see RL22
      end
      MODE_IND, MODE_MAC_IND, MODE_ROFS, MODE_LOFS, MODE_MAC_IDX:
        ea_d = cor_v;                                 // pointer untouched, see RL22 RL4
      default: ;
    endcase
  end

  // pointer file: datapath write-back wins over an apb write to the same entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        pfile_q[i] <= `EAG_ZERO16;
      end
    end else begin
      if (apb_wr && ptr_hit)
        pfile_q[ptr_idx] <= pwdata[W-1:0];
      if (req_valid && wrbk_d)
        pfile_q[req_ptr] <= newptr_d;                                       // see RL22
    end
  end

  // result registers, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_valid_q <= 1'b0;
      ea_addr_q  <= `EAG_ZERO16;
      ea_ydata_q <= 1'b0;
      ea_fault_q <= 1'b0;
      opnd1_q    <= `EAG_ZERO16;
      opnd2_q    <= `EAG_ZERO16;
    end else begin
      ea_valid_q <= req_valid;
      if (req_valid) begin
        ea_addr_q  <= ea_d;
        ea_ydata_q <= ydata_d;
        ea_fault_q <= fault_d;
        opnd1_q    <= base_v;                                               // see RL2
        opnd2_q    <= (req_mode == MODE_LIT) ? lit_v : ptr_v;               // see RL2 RL3
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_file_near: assert property (req_valid && req_mode == MODE_FILE |=> // see RL1
    ea_addr_q == {{(W-`EAG_NEAR_BITS){1'b0}}, $past(req_lit[`EAG_NEAR_BITS-1:0])})
    else $error("file direct address wrong");
  chk_lit_five: assert property (req_valid && req_mode == MODE_LIT // see RL3
    && req_lit_width == LIT_U5 |=> opnd2_q[W-1:`EAG_LIT5_BITS] == '0)
    else $error("5-bit literal not zero extended");
  chk_ind_plain: assert property (req_valid && req_mode == MODE_IND && !mod_x_act // see RL4
    && !mod_y_act && !apb_wr |=> ea_addr_q == $past(ptr_v)
    && pfile_q[$past(req_ptr)] == $past(ptr_v))
    else $error("plain indirect changed pointer or address");
  chk_post_mod: assert property (req_valid && req_mode == MODE_POST && !mod_x_act // see RL5
    && !mod_y_act && !brev_act |=> ea_addr_q == $past(ptr_v)
    && pfile_q[$past(req_ptr)] == $past(ptr_v + req_step))
    else $error("post-modify wrong");
  chk_pre_mod: assert property (req_valid && req_mode == MODE_PRE && !mod_x_act // see RL6
    && !mod_y_act && !brev_act |=> ea_addr_q == $past(ptr_v + req_step))
    else $error("pre-modify wrong");
  chk_reg_offset: assert property (req_valid && req_mode == MODE_ROFS && !mod_x_act // see RL7
    && !mod_y_act |=> ea_addr_q == $past(ptr_v + base_v))
    else $error("register offset sum wrong");
  chk_lit_offset: assert property (req_valid && req_mode == MODE_LOFS && !mod_x_act // see RL8
    && !mod_y_act |=> ea_addr_q == $past(ptr_v + lit_v))
    else $error("literal offset sum wrong");
  chk_mac_route: assert property (req_valid && is_mac && req_ptr >= `EAG_MAC_X0 // see RL10
    && req_ptr <= `EAG_MAC_Y1 |=> ea_ydata_q == ($past(req_ptr) >= `EAG_MAC_Y0))
    else $error("mac pointer routed to wrong space");
  chk_mac_index: assert property (req_valid && req_mode == MODE_MAC_IDX // see RL11
    && req_ptr != `EAG_MAC_X1 && req_ptr != `EAG_MAC_Y1 |=> ea_fault_q)
    else $error("mac index on illegal pointer");
  chk_y_word: assert property (req_valid && mod_y_act && req_mode != MODE_POST // see RL17
    && req_mode != MODE_MAC_POST |=> !ea_addr_q[0])
    else $error("y modulo address odd");
  chk_offset_keep: assert property (req_valid && req_mode == MODE_ROFS && !apb_wr // see RL22
    |=> pfile_q[$past(req_ptr)] == $past(ptr_v))
    else $error("offset mode changed pointer");
  chk_x_wrap: assert property (req_valid && req_mode == MODE_PRE && mod_x_act // see RL24
    && !brev_act && !req_step[W-1] && ptr_v + req_step > xend_q && xend_q >= xstart_q
    |=> ea_addr_q == $past(ptr_v + req_step - (xend_q - xstart_q + 16'h0001)))
    else $error("x wrap by overshoot wrong");

  cov_x_modulo: cover property (req_valid && mod_x_act && req_mode == MODE_POST);
  cov_y_modulo: cover property (req_valid && mod_y_act && req_mode == MODE_PRE);
  cov_brev:     cover property (req_valid && brev_act);
  cov_mac_idx:  cover property (req_valid && req_mode == MODE_MAC_IDX && !fault_d);

endmodule // effective_address_generator

/* mem_port_model.sv */
// mem_port_model.sv: data memory port that records each generated access
// assumes: the result strobe is a one-cycle pulse sampled on rising pclk
`timescale 1ns/1ps
module mem_port_model (
  // clock
  input  wire logic        pclk,
  // access from the generator
  input  wire logic        acc_valid,
  input  wire logic [15:0] acc_addr,
  input  wire logic        acc_y,
  // last access taken
  output logic      [15:0] last_addr,
  output logic             last_y
);
  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // latch each access pulse; nothing else moves the port
  always_ff @(posedge pclk) begin
    if (acc_valid) begin
      last_addr <= acc_addr;
      last_y    <= acc_y;
    end
  end
endmodule // mem_port_model

/* tb_effective_address_generator.sv */
// tb_effective_address_generator.sv: self-checking bench with an integer model
// assumes: eag_pkg, the generator and mem_port_model are compiled first
`timescale 1ns/1ps
module tb_effective_address_generator;
  import eag_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, ea_valid_q, ea_ydata_q, ea_fault_q, last_y;
  gen_type     req_gen = GEN_XRD;
  mode_type    req_mode = MODE_IND;
  lit_type     req_lit_width = LIT_U5;
  logic [3:0]  req_ptr = 0, req_base = 0;
  logic [15:0] req_lit = 0, req_step = 0, ea_addr_q, opnd1_q, opnd2_q, last_addr;
  logic [1:0]  req_mac_step = 0;
  int          failures = 0, n_checks = 0;
  int          w[16], xs, xe, ys, ye, mc, p;
  int          lmax[4] = '{16'h001F, 16'h03FF, 16'h3FFF, 16'hFFFF};

  effective_address_generator uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_gen, .req_mode, .req_ptr,
    .req_base, .req_lit, .req_lit_width, .req_step, .req_mac_step, .ea_valid_q,
    .ea_addr_q, .ea_ydata_q, .ea_fault_q, .opnd1_q, .opnd2_q);
  mem_port_model mem (.pclk, .acc_valid(ea_valid_q), .acc_addr(ea_addr_q),
    .acc_y(ea_ydata_q), .last_addr, .last_y);

  // 40 mhz clock
  always #12.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input int d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wrt(input logic [7:0] a, input int d);
    logic [31:0] r; logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rreg(input logic [7:0] a, input int x, input bit xe = 0);
    logic [31:0] r; logic e;
    apb(0, a, 0, r, e);
    check(r, x);
    check(e, xe);
  endtask
  task automatic setmod(input int a, b, c, d, m);
    xs = a; xe = b; ys = c; ye = d; mc = m;
    wrt(8'h04, a); wrt(8'h08, b); wrt(8'h0C, c); wrt(8'h10, d); wrt(8'h00, m);
  endtask
  task automatic setptr(input int i, v);
    w[i] = v;
    wrt(8'h40 + 4 * i, v);
  endtask
  // one-way wrap unless the length is a power of two; y words stay even
  function automatic int wrap(int v, bit y, bit up);
    int s, e, n;
    s = y ? ys : xs;
    e = y ? ye : xe;
    n = e - s + 1;
    v = v & 16'hFFFF;
    if (v > e && (up || (n & (n - 1)) == 0)) v = v - n;
    else if (v < s && (!up || (n & (n - 1)) == 0)) v = v + n;
    return y ? v & 16'hFFFE : v;
  endfunction
  // issue one request, predict it, compare outputs and the memory port
  task automatic run(input gen_type g, input mode_type m, input int p, b, l, s,
                     input int ms = 0, input lit_type lw = LIT_U5);
    int ea, np, o2, ad;
    bit y, f, mac, up;
    mac = m >= MODE_MAC_IND;
    y = mac ? p >= 10 : g == GEN_Y;
    f = mac && (p < 8 || p > 11 || (m == MODE_MAC_IDX && p % 2 == 0)
        || (m == MODE_MAC_POST && ms == 0));
    ad = 0;
    np = w[p]; ea = w[p]; o2 = (m == MODE_LIT) ? l & lmax[lw] : w[p];
    case (m)
      MODE_FILE: ea = l & 16'h1FFF;
      MODE_DIRECT, MODE_LIT: ea = 0;
      MODE_POST, MODE_PRE: ad = s;
      MODE_MAC_POST: ad = 2 * ms;
      MODE_ROFS, MODE_MAC_IDX: ad = w[b];
      MODE_LOFS: ad = l & lmax[lw];
      default: ;
    endcase
    up = !ad[15];
    if (m inside {MODE_POST, MODE_PRE, MODE_MAC_POST}) np = w[p] + ad;
    else if (!(m inside {MODE_FILE, MODE_DIRECT, MODE_LIT})) ea = w[p] + ad;
    if (p != 15 && (y ? mc[14] && mc[7:4] == p : mc[15] && mc[3:0] == p)) begin
      if (m inside {MODE_POST, MODE_PRE, MODE_MAC_POST}) np = wrap(np, y, up);
      else if (!(m inside {MODE_FILE, MODE_DIRECT, MODE_LIT})) ea = wrap(ea, y, up);
    end
    if (m == MODE_PRE) ea = np;
    @(posedge pclk);
    req_valid <= 1; req_gen <= g; req_mode <= m; req_ptr <= p; req_base <= b;
    req_lit <= l; req_step <= s; req_mac_step <= ms; req_lit_width <= lw;
    @(posedge pclk);
    req_valid <= 0;
    #1 check(ea_valid_q, 1);
    check(ea_fault_q, f);
    check(opnd1_q, w[b] & 16'hFFFF);
    check(opnd2_q, o2 & 16'hFFFF);
    if (!f) check(ea_addr_q, ea & 16'hFFFF);
    if (!f) check(ea_ydata_q, y);
    @(posedge pclk);
    #1 if (!f) check(last_addr, ea & 16'hFFFF);
    check(ea_valid_q, 0);
    if (!f) w[p] = np & 16'hFFFF;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h51b91c47));
    mc = 16'h0FFF;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rreg(8'h00, 16'h0FFF);
    rreg(8'h08, 0);
    rreg(8'h30, 0, 1);
    for (int i = 0; i < 16; i++) setptr(i, $urandom & 16'hFFFE);
    rreg(8'h54, w[5]);
    repeat (30) begin
      p = $urandom_range(3);
      run(gen_type'($urandom_range(2)), mode_type'(3 + $urandom_range(4)), p,
          4 + $urandom_range(3), $urandom & 16'h00FE, ($urandom_range(16) - 8) * 2);
    end
    foreach (lmax[i]) run(GEN_XRD, MODE_LIT, 0, 4, $urandom & 16'hFFFF, 0, 0, lit_type'(i));
    run(GEN_XRD, MODE_FILE, 0, 4, 16'hFFFE, 0);
    run(GEN_XRD, MODE_DIRECT, 0, 5, 0, 0);
    for (int i = 7; i < 13; i++) begin
      run(GEN_XRD, MODE_MAC_IND, i, 4, 0, 0);
      run(GEN_XRD, MODE_MAC_IDX, i, 4, 0, 0);
      for (int k = 0; k < 4; k++) run(GEN_XRD, MODE_MAC_POST, i, 4, 0, 0, k);
    end
    setmod(16'h1100, 16'h1163, 16'h2000, 16'h201F, 16'h8001);
    setptr(1, 16'h1162);
    run(GEN_XWR, MODE_POST, 1, 4, 0, 2);
    run(GEN_XRD, MODE_PRE, 1, 4, 0, 16'h66);
    run(GEN_XRD, MODE_LOFS, 1, 4, 16'h70, 0, 0, LIT_U10);
    rreg(8'h44, w[1]);
    setmod(16'h1100, 16'h1163, 16'h2000, 16'h201F, 16'h0001);
    run(GEN_XRD, MODE_POST, 1, 4, 0, 16'h70);
    setmod(16'h1100, 16'h1163, 16'h2000, 16'h201F, 16'hC02F);
    setptr(15, 16'h1162);
    run(GEN_XRD, MODE_POST, 15, 4, 0, 2);
    setptr(2, 16'h2000);
    run(GEN_Y, MODE_PRE, 2, 4, 0, -2);
    run(GEN_Y, MODE_POST, 2, 4, 0, 4);
    setmod(16'h1100, 16'h1163, 16'h2000, 16'h201F, 16'h802F);
    run(GEN_Y, MODE_POST, 2, 4, 0, 16'h20);
    // bit-reversed writes on pointer 3, modifier 8 words: 1000, 1010, 1008
    mc = 16'h03FF;
    wrt(8'h00, mc);
    wrt(8'h14, 16'h8008);
    setptr(3, 16'h1000);
    run(GEN_XWR, MODE_POST, 3, 4, 0, 2);
    w[3] = 16'h1010;
    rreg(8'h4C, w[3]);
    run(GEN_XWR, MODE_POST, 3, 4, 0, 2);
    w[3] = 16'h1008;
    rreg(8'h4C, w[3]);
    run(GEN_XRD, MODE_POST, 3, 4, 0, 2);
    rreg(8'h4C, 16'h100A);
    print_verdict();
  end

  // watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    print_verdict();
  end
endmodule // tb_effective_address_generator
